// File: astrc_pkg.sv
package astrc_pkg;

   // ==========================================================
   // register map, byte addresses
   localparam logic [7:0] ADDR_CTRL = 8'h00;
   localparam logic [7:0] ADDR_STAT = 8'h04;
   localparam logic [7:0] ADDR_DATA = 8'h08;
   localparam logic [7:0] ADDR_BAUD = 8'h0C;

   // ==========================================================
   // uart_control_one field positions
   localparam int CTRL_WIDTH  = 11;
   localparam int C_WORD_LEN  = 0;
   localparam int C_PAR_ODD   = 1;
   localparam int C_PAR_EN    = 2;
   localparam int C_STOP_TWO  = 3;
   localparam int C_TX_NINTH  = 4;
   localparam int C_TX_EN     = 5;
   localparam int C_RX_EN     = 6;
   localparam int C_BREAK     = 7;
   localparam int C_TX_IE     = 8;
   localparam int C_RX_IE     = 9;
   localparam int C_BAUD_HS   = 10;

   // ==========================================================
   // uart_status_reg field positions
   localparam int S_TX_EMPTY  = 0;
   localparam int S_TX_IDLE   = 1;
   localparam int S_RX_AVAIL  = 2;
   localparam int S_OVERRUN   = 3;
   localparam int S_FRAMING   = 4;
   localparam int S_PARITY    = 5;
   localparam int S_NOISE     = 6;
   localparam int S_RX_IDLE   = 7;
   localparam int S_RX_NINTH  = 8;

   // ==========================================================
   // reset values
   localparam logic [CTRL_WIDTH-1:0] CTRL_RESET = 11'h000;
   localparam logic [7:0]            BAUD_RESET = 8'h00;

   // ==========================================================
   // timing counts
   localparam logic [1:0] PRE_LAST   = 2'h3;
   localparam logic [3:0] OS_SAMPLE0 = 4'h7;
   localparam logic [3:0] OS_SAMPLE1 = 4'h8;
   localparam logic [3:0] OS_VOTE    = 4'h9;
   localparam logic [3:0] OS_LAST    = 4'hF;
   localparam logic [3:0] BREAK_LAST = 4'hC;
   localparam logic [3:0] BITS_EIGHT = 4'h8;
   localparam logic [3:0] BITS_NINE  = 4'h9;

   // ==========================================================
   // state encodings
   typedef enum logic [4:0] {
      TX_IDLE  = 5'h01,
      TX_START = 5'h02,
      TX_DATA  = 5'h04,
      TX_PAR   = 5'h08,
      TX_STOP  = 5'h10
   } astrc_tx_state_t;

   typedef enum logic [5:0] {
      RX_IDLE  = 6'h01,
      RX_START = 6'h02,
      RX_DATA  = 6'h04,
      RX_PAR   = 6'h08,
      RX_STOP  = 6'h10,
      RX_WAIT  = 6'h20
   } astrc_rx_state_t;

endpackage

// File: astrc_core.sv
// Register access over APB and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
module astrc_core
   import astrc_pkg::*;
(
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        rx_in,
   output logic             tx_out,
   output logic             irq
);

   // ==========================================================
   // state
   typedef struct packed {
      logic [CTRL_WIDTH-1:0] ctrl;
      logic [7:0]            baud;
      logic                  armed;
      logic                  pready;
      logic                  pslverr;
      logic [31:0]           prdata;
      logic                  irq;
      logic [7:0]            pre_cnt;
      logic [1:0]            div4;
      astrc_tx_state_t       tx_state;
      logic                  tx_pin;
      logic [8:0]            tx_shift_reg;
      logic [3:0]            tx_os;
      logic [3:0]            tx_bits;
      logic                  tx_par;
      logic                  tx_brk;
      logic [8:0]            tx_buf;
      logic                  tx_buf_full;
      logic                  tx_buffer_empty_flag;
      logic                  tx_idle_flag;
      logic [8:0]            brk_cnt;
      logic                  brk_ok;
      astrc_rx_state_t       rx_state;
      logic [3:0]            rx_os;
      logic [1:0]            rx_samp;
      logic [8:0]            rx_shift_reg;
      logic [3:0]            rx_bits;
      logic                  rx_par;
      logic                  rx_parity_error_flag;
      logic                  rx_noise;
      logic                  rx_prev;
      logic [1:0][11:0]      fifo;
      logic                  rd_ptr;
      logic [1:0]            fifo_cnt;
      logic                  overrun_flag;
      logic                  rx_idle_flag;
   } astrc_state_t;

   astrc_state_t s;
   astrc_state_t next_s;

   logic        setup;
   logic        acc;
   logic        wr;
   logic        rd;
   logic        dw;
   logic        direct;
   logic        os_pre;
   logic        os_tick;
   logic        tx_tick;
   logic        rx_vote;
   logic        vote;
   logic        unan;
   logic        tx_buffer_empty_flag_set;
   logic        tx_idle_flag_set;
   logic        push;
   logic [3:0]  nd;
   logic [8:0]  word;
   logic [11:0] head;
   logic [11:0] entry;

   always_comb
   begin
      next_s = s;

      // =======================================================
      // common timing
      nd   = (s.ctrl[C_WORD_LEN] ? BITS_NINE : BITS_EIGHT) - {3'h0, s.ctrl[C_PAR_EN]};
      head = s.fifo[s.rd_ptr];
      os_pre = (s.pre_cnt == s.baud);
      os_tick = os_pre & (s.ctrl[C_BAUD_HS] | (s.div4 == PRE_LAST));
      next_s.pre_cnt = os_pre ? 8'h00 : s.pre_cnt + 8'h01;
      if (os_pre)
      begin
         next_s.div4 = s.div4 + 2'h1;
      end
      tx_tick = os_tick & (s.tx_os == OS_LAST);

      // =======================================================
      // apb slave: zero wait, answer prepared in setup cycle
      setup = psel & ~penable;
      acc   = psel & penable & s.pready;
      wr    = acc & pwrite;
      rd    = acc & ~pwrite;
      next_s.pready  = setup;
      next_s.pslverr = 1'b0;
      next_s.prdata  = 32'h0000_0000;
      if (setup)
      begin
         if (paddr == ADDR_CTRL)
         begin
            next_s.prdata[CTRL_WIDTH-1:0] = s.ctrl;
         end
         else if (paddr == ADDR_STAT)
         begin
            next_s.prdata[S_TX_EMPTY] = s.tx_buffer_empty_flag;
            next_s.prdata[S_TX_IDLE]  = s.tx_idle_flag;
            next_s.prdata[S_RX_AVAIL] = (s.fifo_cnt != 2'h0);
            next_s.prdata[S_OVERRUN]  = s.overrun_flag;
            next_s.prdata[S_FRAMING]  = head[9];
            next_s.prdata[S_PARITY]   = head[10];
            next_s.prdata[S_NOISE]    = head[11];
            next_s.prdata[S_RX_IDLE]  = s.rx_idle_flag;
            next_s.prdata[S_RX_NINTH] = head[8] & s.ctrl[C_WORD_LEN];
         end
         else if (paddr == ADDR_DATA)
         begin
            next_s.prdata[7:0] = head[7:0];
         end
         else if (paddr == ADDR_BAUD)
         begin
            next_s.prdata[7:0] = s.baud;
         end
         else
         begin
            next_s.pslverr = 1'b1;
         end
      end
      if (wr & (paddr == ADDR_CTRL))
      begin
         next_s.ctrl = pwdata[CTRL_WIDTH-1:0];
      end
      if (wr & (paddr == ADDR_BAUD))
      begin
         next_s.baud = pwdata[7:0];
      end

      // =======================================================
      // break qualification
      if (s.ctrl[C_BREAK] & s.tx_idle_flag & (s.tx_state == TX_IDLE))
      begin
         if (s.brk_cnt > ({1'b0, s.baud} + 9'h001))
         begin
            next_s.brk_ok = 1'b1;
         end
         else
         begin
            next_s.brk_cnt = s.brk_cnt + 9'h001;
         end
      end
      else if (~s.ctrl[C_BREAK])
      begin
         next_s.brk_cnt = 9'h000;
         next_s.brk_ok  = 1'b0;
      end

      // =======================================================
      // transmitter
      tx_buffer_empty_flag_set  = 1'b0;
      tx_idle_flag_set = 1'b0;
      if (os_tick & (s.tx_state != TX_IDLE))
      begin
         next_s.tx_os = s.tx_os + 4'h1;
      end
      case (s.tx_state)
         TX_IDLE:
         begin
            next_s.tx_pin = 1'b1;
            next_s.tx_os  = 4'h0;
            next_s.tx_par = 1'b0;
            if (s.ctrl[C_TX_EN] & s.brk_ok)
            begin
               next_s.tx_state = TX_START;
               next_s.tx_brk   = 1'b1;
               next_s.brk_ok   = 1'b0;
               next_s.brk_cnt  = 9'h000;
            end
            else if (s.ctrl[C_TX_EN] & s.tx_buf_full)
            begin
               next_s.tx_state     = TX_START;
               next_s.tx_shift_reg = s.tx_buf;
               next_s.tx_buf_full  = 1'b0;
               tx_buffer_empty_flag_set            = 1'b1;
            end
         end
         TX_START:
         begin
            next_s.tx_pin = 1'b0;
            if (tx_tick)
            begin
               next_s.tx_state = TX_DATA;
               next_s.tx_bits  = 4'h0;
            end
         end
         TX_DATA:
         begin
            next_s.tx_pin = s.tx_brk ? 1'b0 : s.tx_shift_reg[s.tx_bits];
            if (tx_tick)
            begin
               next_s.tx_par  = s.tx_par ^ s.tx_pin;
               next_s.tx_bits = s.tx_bits + 4'h1;
               if (s.tx_brk)
               begin
                  if (s.tx_bits == BREAK_LAST)
                  begin
                     next_s.tx_bits = 4'h0;
                     if (~s.ctrl[C_BREAK])
                     begin
                        next_s.tx_state = TX_STOP;
                     end
                  end
               end
               else if (s.tx_bits == nd - 4'h1)
               begin
                  next_s.tx_state = s.ctrl[C_PAR_EN] ? TX_PAR : TX_STOP;
                  next_s.tx_bits  = 4'h0;
               end
            end
         end
         TX_PAR:
         begin
            next_s.tx_pin = s.tx_par ^ s.ctrl[C_PAR_ODD];
            if (tx_tick)
            begin
               next_s.tx_state = TX_STOP;
            end
         end
         TX_STOP:
         begin
            next_s.tx_pin = 1'b1;
            if (tx_tick)
            begin
               if (s.ctrl[C_STOP_TWO] & (s.tx_bits == 4'h0))
               begin
                  next_s.tx_bits = 4'h1;
               end
               else
               begin
                  tx_idle_flag_set      = 1'b1;
                  next_s.tx_brk  = 1'b0;
                  next_s.tx_par  = 1'b0;
                  next_s.tx_os   = 4'h0;
                  next_s.tx_bits = 4'h0;
                  if (s.tx_buf_full)
                  begin
                     next_s.tx_state     = TX_START;
                     next_s.tx_shift_reg = s.tx_buf;
                     next_s.tx_buf_full  = 1'b0;
                     tx_buffer_empty_flag_set            = 1'b1;
                  end
                  else
                  begin
                     next_s.tx_state = TX_IDLE;
                  end
               end
            end
         end
         default:
         begin
            next_s.tx_state = TX_IDLE;
         end
      endcase
      if (~s.ctrl[C_TX_EN])
      begin
         next_s.tx_state = TX_IDLE;
         next_s.tx_pin   = 1'b1;
         next_s.tx_brk   = 1'b0;
      end

      // data write; refused while the empty flag is low
      word   = {s.ctrl[C_TX_NINTH] & s.ctrl[C_WORD_LEN], pwdata[7:0]};
      dw     = wr & (paddr == ADDR_DATA) & s.tx_buffer_empty_flag;
      direct = (s.tx_state == TX_IDLE) & ~s.tx_buf_full & s.ctrl[C_TX_EN] & ~s.brk_ok;
      if (dw)
      begin
         if (s.armed)
         begin
            next_s.tx_buffer_empty_flag = 1'b0;
            next_s.tx_idle_flag         = 1'b0;
         end
         if (direct)
         begin
            next_s.tx_state     = TX_START;
            next_s.tx_shift_reg = word;
            next_s.tx_brk       = 1'b0;
            tx_buffer_empty_flag_set            = 1'b1;
         end
         else
         begin
            next_s.tx_buf      = word;
            next_s.tx_buf_full = 1'b1;
         end
      end
      // hardware set wins over the software clear
      next_s.tx_buffer_empty_flag = next_s.tx_buffer_empty_flag | tx_buffer_empty_flag_set;
      next_s.tx_idle_flag         = next_s.tx_idle_flag | tx_idle_flag_set;

      // =======================================================
      // receiver: 16x recovery, vote at mid-bit
      next_s.rx_prev = rx_in;
      rx_vote = os_tick & (s.rx_os == OS_VOTE);
      vote = (s.rx_samp[0] & s.rx_samp[1]) | (s.rx_samp[0] & rx_in) | (s.rx_samp[1] & rx_in);
      unan = (s.rx_samp[0] == s.rx_samp[1]) & (s.rx_samp[1] == rx_in);
      if (os_tick & (s.rx_state != RX_IDLE))
      begin
         next_s.rx_os = s.rx_os + 4'h1;
         if (s.rx_os == OS_SAMPLE0)
         begin
            next_s.rx_samp[0] = rx_in;
         end
         if (s.rx_os == OS_SAMPLE1)
         begin
            next_s.rx_samp[1] = rx_in;
         end
      end
      push  = 1'b0;
      entry = {s.rx_noise | ~unan, s.rx_parity_error_flag, ~vote, s.rx_shift_reg};
      case (s.rx_state)
         RX_IDLE:
         begin
            next_s.rx_os = 4'h0;
            if (s.ctrl[C_RX_EN] & s.rx_prev & ~rx_in)
            begin
               next_s.rx_state     = RX_START;
               next_s.rx_noise     = 1'b0;
               next_s.rx_parity_error_flag      = 1'b0;
               next_s.rx_par       = 1'b0;
               next_s.rx_shift_reg = 9'h000;
            end
         end
         RX_START:
         begin
            if (rx_vote)
            begin
               if (~vote)
               begin
                  next_s.rx_state     = RX_DATA;
                  next_s.rx_bits      = 4'h0;
                  next_s.rx_idle_flag = 1'b0;
                  next_s.rx_noise     = ~unan;
               end
               else
               begin
                  next_s.rx_state = RX_IDLE;
               end
            end
         end
         RX_DATA:
         begin
            if (rx_vote)
            begin
               next_s.rx_shift_reg[s.rx_bits] = vote;
               next_s.rx_par   = s.rx_par ^ vote;
               next_s.rx_noise = s.rx_noise | ~unan;
               next_s.rx_bits  = s.rx_bits + 4'h1;
               if (s.rx_bits == nd - 4'h1)
               begin
                  next_s.rx_state = s.ctrl[C_PAR_EN] ? RX_PAR : RX_STOP;
               end
            end
         end
         RX_PAR:
         begin
            if (rx_vote)
            begin
               next_s.rx_parity_error_flag  = vote ^ s.rx_par ^ s.ctrl[C_PAR_ODD];
               next_s.rx_noise = s.rx_noise | ~unan;
               next_s.rx_state = RX_STOP;
            end
         end
         RX_STOP:
         begin
            if (rx_vote)
            begin
               // only one stop is checked; a second one is just idle line
               push                = 1'b1;
               next_s.rx_idle_flag = 1'b1;
               next_s.rx_state     = vote ? RX_IDLE : RX_WAIT;
            end
         end
         RX_WAIT:
         begin
            if (rx_in)
            begin
               next_s.rx_state = RX_IDLE;
            end
         end
         default:
         begin
            next_s.rx_state = RX_IDLE;
         end
      endcase
      if (~s.ctrl[C_RX_EN])
      begin
         next_s.rx_state     = RX_IDLE;
         next_s.rx_idle_flag = 1'b1;
         push                = 1'b0;
      end

      // =======================================================
      // receive fifo: pop only after a status access
      if (rd & (paddr == ADDR_DATA) & s.armed & (s.fifo_cnt != 2'h0))
      begin
         next_s.rd_ptr       = ~s.rd_ptr;
         next_s.fifo_cnt     = s.fifo_cnt - 2'h1;
         next_s.overrun_flag = 1'b0;
      end
      if (push)
      begin
         if (next_s.fifo_cnt == 2'h2)
         begin
            next_s.overrun_flag = 1'b1;
         end
         else
         begin
            next_s.fifo[next_s.rd_ptr ^ next_s.fifo_cnt[0]] = entry;
            next_s.fifo_cnt = next_s.fifo_cnt + 2'h1;
         end
      end

      // status access arms, any data access disarms
      if (acc & (paddr == ADDR_STAT))
      begin
         next_s.armed = 1'b1;
      end
      else if (acc & (paddr == ADDR_DATA))
      begin
         next_s.armed = 1'b0;
      end

      // break frames never touch the empty flag, so no irq
      next_s.irq = (next_s.ctrl[C_TX_IE] & next_s.tx_buffer_empty_flag)
                 | (next_s.ctrl[C_RX_IE]
                    & ((next_s.fifo_cnt != 2'h0) | next_s.overrun_flag));
   end

   // ==========================================================
   // registers
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         s                      <= '0;
         s.ctrl                 <= CTRL_RESET;
         s.baud                 <= BAUD_RESET;
         s.tx_state             <= TX_IDLE;
         s.rx_state             <= RX_IDLE;
         s.tx_pin               <= 1'b1;
         s.tx_buffer_empty_flag <= 1'b1;
         s.tx_idle_flag         <= 1'b1;
         s.rx_idle_flag         <= 1'b1;
         s.rx_prev              <= 1'b1;
      end
      else
      begin
         s <= next_s;
      end
   end

   assign prdata  = s.prdata;
   assign pready  = s.pready;
   assign pslverr = s.pslverr;
   assign tx_out  = s.tx_pin;
   assign irq     = s.irq;

endmodule // astrc_core

// File: astrc_chk.sv
`timescale 1ns/1ps
module astrc_chk
   import astrc_pkg::*;
(
   input wire logic        pclk,
   input wire logic        presetn,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [7:0]  paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   input wire logic        rx_in,
   input wire logic        tx_out,
   input wire logic        irq
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   logic mapped;
   logic ctrl_wr;
   assign mapped  = paddr inside {ADDR_CTRL, ADDR_STAT, ADDR_DATA, ADDR_BAUD};
   assign ctrl_wr = pready && pwrite && paddr == ADDR_CTRL;
   // ======
   // apb timing
   ready_in_access_a: assert property (psel && !penable |=> pready)
      else $error("pready missing in access cycle");
   ready_one_cycle_a: assert property (pready |=> !pready)
      else $error("pready held past one cycle");
   ready_needs_req_a: assert property (pready |-> psel && penable)
      else $error("pready without a request");
   unmapped_refused_a: assert property (pready && !mapped |-> pslverr && prdata == 32'h0)
      else $error("unmapped access not refused");
   mapped_accepted_a: assert property (pready && mapped |-> !pslverr)
      else $error("mapped access refused");
   error_with_ready_a: assert property (!pready |-> !pslverr)
      else $error("pslverr outside access");
   // ======
   // serial pin and interrupt
   // fastest divisor still gives 16 cycles a bit
   tx_bit_hold_a: assert property (!$stable(tx_out) |=> $stable(tx_out)[*8])
      else $error("tx bit shorter than allowed");
   irq_masked_a: assert property (ctrl_wr && !pwdata[C_TX_IE] && !pwdata[C_RX_IE] |-> ##2 !irq)
      else $error("irq high with both enables clear");
   tx_off_idle_a: assert property (ctrl_wr && !pwdata[C_TX_EN] |-> ##3 tx_out[*4])
      else $error("tx pin not idle high when disabled");
endmodule // astrc_chk

bind astrc_core astrc_chk u_astrc_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
   .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
   .pready(pready), .pslverr(pslverr), .rx_in(rx_in), .tx_out(tx_out), .irq(irq));

// File: astrc_remote.sv
`timescale 1ns/1ps
module astrc_remote #(parameter int BIT = 16)
(
   input  wire logic clk,
   input  wire logic line_in,
   output logic      line_out
);
   // ======
   // far end, sampling on the falling clock edge to stay clear of the launch edge
   initial line_out = 1'b1;
   task automatic send(input logic [8:0] d, input int nb, input logic stop);
      @(posedge clk);
      line_out <= 1'b0;
      repeat (BIT) @(posedge clk);
      for (int i = 0; i < nb; i++)
      begin
         line_out <= d[i];
         repeat (BIT) @(posedge clk);
      end
      line_out <= stop;
      repeat (BIT) @(posedge clk);
      line_out <= 1'b1;
      repeat (BIT) @(posedge clk);
   endtask
   task automatic recv(input int nb, output logic [8:0] d);
      int n;
      d = 9'h000;
      n = 0;
      while (line_in !== 1'b0 && n < 5000)
      begin
         @(negedge clk);
         n++;
      end
      repeat (BIT / 2) @(negedge clk);
      for (int i = 0; i < nb; i++)
      begin
         repeat (BIT) @(negedge clk);
         d[i] = line_in;
      end
      // end in mid stop bit so a following call sees the next fall
      repeat (BIT) @(negedge clk);
   endtask
   task automatic low_len(output int low);
      int n;
      n = 0;
      low = 0;
      while (line_in !== 1'b0 && n < 5000)
      begin
         @(negedge clk);
         n++;
      end
      while (line_in === 1'b0 && low < 3000)
      begin
         low++;
         @(negedge clk);
      end
   endtask
endmodule // astrc_remote

// File: tb.sv
`timescale 1ns/1ps
module tb;
   import astrc_pkg::*;
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, rx_in, tx_out, irq;
   logic        err;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [8:0]  got;
   int          failures, checked, low;
   localparam logic [31:0] CFG  = 32'h0000_0760;
   localparam logic [31:0] CFGR = 32'h0000_0660;

   astrc_core u_astrc_core (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .rx_in(rx_in), .tx_out(tx_out), .irq(irq));
   astrc_remote u_astrc_remote (.clk(pclk), .line_in(tx_out), .line_out(rx_in));

   always #5 pclk = ~pclk;
   // ======
   // bus and compare tasks
   task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp)
      begin
         failures++;
         $display("MISMATCH %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic finish_test();
      $display("comparisons %0d mismatches %0d", checked, failures);
      if (failures == 0 && checked > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      // request held until the edge that sees pready high
      @(posedge pclk);
      while (pready !== 1'b1)
      begin
         n++;
         if (n > 50)
         begin
            failures++;
            finish_test();
         end
         @(posedge pclk);
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic rdchk(input logic [7:0] a, input logic [31:0] exp, input string what);
      apb(1'b0, a, 32'h0);
      chk(what, rd, exp);
   endtask
   // ======
   // main sequence
   initial
   begin
      pclk = 1'b0;
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      failures = 0;
      checked = 0;
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
      chk("tx idle", {31'h0, tx_out}, 32'h1);
      rdchk(ADDR_STAT, 32'h83, "status reset");
      rdchk(ADDR_CTRL, 32'h0, "ctrl reset");
      apb(1'b0, 8'h10, 32'h0);
      chk("unmapped err", {31'h0, err}, 32'h1);
      $display("test reset done");
      apb(1'b1, ADDR_BAUD, 32'h0);
      apb(1'b1, ADDR_CTRL, CFG);
      fork
         begin
            u_astrc_remote.recv(8, got);
            chk("first frame", {23'h0, got}, 32'hA5);
            u_astrc_remote.recv(8, got);
            chk("held frame", {23'h0, got}, 32'h3C);
         end
         begin
            rdchk(ADDR_STAT, 32'h83, "arm");
            apb(1'b1, ADDR_DATA, 32'hA5);
            rdchk(ADDR_STAT, 32'h81, "direct load");
            apb(1'b1, ADDR_DATA, 32'h3C);
            rdchk(ADDR_STAT, 32'h80, "buffer full");
            chk("irq full", {31'h0, irq}, 32'h0);
            apb(1'b1, ADDR_DATA, 32'hFF);
         end
      join
      repeat (16) @(posedge pclk);
      rdchk(ADDR_STAT, 32'h83, "tx done");
      chk("irq empty", {31'h0, irq}, 32'h1);
      apb(1'b1, ADDR_CTRL, CFG | 32'h11);
      rdchk(ADDR_STAT, 32'h83, "arm");
      fork
         u_astrc_remote.recv(9, got);
         apb(1'b1, ADDR_DATA, 32'h5A);
      join
      chk("ninth bit", {23'h0, got}, 32'h15A);
      $display("test transmit done");
      apb(1'b1, ADDR_CTRL, CFG | 32'h80);
      fork
         u_astrc_remote.low_len(low);
         begin
            repeat (60) @(posedge pclk);
            apb(1'b1, ADDR_CTRL, CFG);
         end
      join
      chk("break low", low, 32'd224);
      repeat (20) @(posedge pclk);
      rdchk(ADDR_STAT, 32'h83, "after break");
      $display("test break done");
      apb(1'b1, ADDR_CTRL, CFGR);
      // irq registers at the write edge itself; look once it has settled
      @(negedge pclk);
      chk("irq quiet", {31'h0, irq}, 32'h0);
      u_astrc_remote.send(9'h05A, 8, 1'b1);
      u_astrc_remote.send(9'h0C3, 8, 1'b1);
      rdchk(ADDR_STAT, 32'h87, "two words");
      chk("irq rx", {31'h0, irq}, 32'h1);
      rdchk(ADDR_DATA, 32'h5A, "word one");
      rdchk(ADDR_STAT, 32'h87, "one left");
      rdchk(ADDR_DATA, 32'hC3, "word two");
      for (int i = 1; i <= 3; i++)
         u_astrc_remote.send(9'(8'h11 * i), 8, 1'b1);
      rdchk(ADDR_STAT, 32'h8F, "overrun");
      rdchk(ADDR_DATA, 32'h11, "kept word");
      rdchk(ADDR_STAT, 32'h87, "overrun clear");
      rdchk(ADDR_DATA, 32'h22, "last kept");
      u_astrc_remote.send(9'h000, 8, 1'b0);
      rdchk(ADDR_STAT, 32'h97, "framing");
      rdchk(ADDR_DATA, 32'h00, "break zeros");
      apb(1'b1, ADDR_CTRL, CFGR | 32'h1);
      u_astrc_remote.send(9'h1A5, 9, 1'b1);
      rdchk(ADDR_STAT, 32'h187, "rx ninth");
      rdchk(ADDR_DATA, 32'hA5, "rx nine data");
      $display("test receive done");
      apb(1'b1, ADDR_CTRL, 32'h0);
      repeat (3) @(posedge pclk);
      chk("irq off", {31'h0, irq}, 32'h0);
      finish_test();
   end
endmodule // tb
